// ### include/analog_sel_pkg.sv
// Constants shared by the analog source selector and its input filter.
// Assumes a 32-bit APB with byte addresses and a 200 MHz clock.
package analog_sel_pkg;

  // Register byte offsets
  localparam logic [7:0] CFG_OFF        = 8'h00;
  localparam logic [7:0] STATUS_OFF     = 8'h04;
  localparam logic [7:0] OUT_ASSIGN_OFF = 8'h08;
  localparam logic [7:0] CMD_OFF        = 8'h0c;

  // Configuration field positions
  localparam int FREQ_SRC_LSB = 0;
  localparam int RUN_SRC_LSB  = 4;
  localparam int SEL_MODE_BIT = 8;
  localparam int AUX_MODE_LSB = 10;
  localparam int SEL_ASG_BIT  = 12;
  localparam int FILTER_LSB   = 16;

  // Reset values
  localparam logic [2:0] FREQ_SRC_RST = 3'h1;
  localparam logic [2:0] RUN_SRC_RST  = 3'h1;
  localparam logic       SEL_MODE_RST = 1'b0;
  localparam logic [1:0] AUX_MODE_RST = 2'h0;
  localparam logic       SEL_ASG_RST  = 1'b1;
  localparam logic [4:0] FILTER_RST   = 5'h08;
  localparam logic [7:0] OUT_CODE_RST = 8'h00;

  // Setting codes
  localparam logic [2:0] RUN_SRC_KEYPAD = 3'h2;
  localparam logic [2:0] FREQ_SRC_ANALOG = 3'h1;
  localparam logic [7:0] RUN_MON_CODE   = 8'h1b;
  localparam logic [4:0] FILTER_MIN     = 5'h01;
  localparam logic [4:0] FILTER_MAX     = 5'h1e;
  localparam int         FILTER_SHIFT   = 2;

  typedef enum logic [1:0] {
    AUX_BIPOLAR   = 2'b00,
    AUX_UNIPOLAR  = 2'b01,
    AUX_REVERSE   = 2'b10,
    AUX_NO_TRIM   = 2'b11
  } aux_mode_t;

  typedef enum logic [1:0] {
    SRC_VOLT = 2'b00,
    SRC_CUR  = 2'b01,
    SRC_BIP  = 2'b10,
    SRC_SUM  = 2'b11
  } main_src_t;

endpackage

// ### include/filt_if.sv
// Carries raw samples and the filter setting to the filter, results back.
// Assumes both ends run on the same clock.
interface filt_if;
  logic [4:0]       setting;
  logic [2:0][11:0] raw;
  logic [2:0][11:0] filt;
  modport core (output setting, output raw, input filt);
  modport flt  (input setting, input raw, output filt);
endinterface

// ### design/sample_filter.sv
// Shared sampling filter for the three analog channels.
// Assumes samples arrive on clk and the setting lies in its legal range.
module sample_filter (
  input  wire logic clk,
  input  wire logic nrst,
  filt_if.flt       f
);
  typedef struct packed {
    logic [4:0]       div;
    logic [2:0][11:0] y;
  } flt_state_t;

  flt_state_t st_reg;
  flt_state_t st_next;
  logic signed [12:0] diff;

  always_comb begin
    diff    = 13'sh0;
    st_next = st_reg;
    // Update rate falls as the setting grows
    if (st_reg.div + 5'h01 >= f.setting) begin
      st_next.div = 5'h00;
      for (int i = 0; i < 3; i++) begin
        diff = $signed({f.raw[i][11], f.raw[i]}) - $signed({st_reg.y[i][11], st_reg.y[i]});
        st_next.y[i] = st_reg.y[i] + 12'(diff >>> analog_sel_pkg::FILTER_SHIFT);
      end
    end else begin
      st_next.div = st_reg.div + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign f.filt = st_reg.y;
endmodule

// ### design/analog_input_source_selector.sv
// Analog input source selector with APB register file and run source monitor.
// Assumes ADC samples are synchronous to clk; the selector pin is asynchronous.
//
// Overview of operation
// - Monitor on only when run source is keypad.
// - Output code 27 selects the run monitor.
// - Network writes cannot assign or remove monitor.
// - Network may still read monitor assignments.
// - Selector off gives voltage, on gives current.
// - Analog command used only with source 01.
// - One filter setting 1..30 for all inputs.
// - Modes and selector choose main, trim, reverse.
// - Trim only where allowed, never modes 00/03.
// - Reverse only where allowed; sign sets direction.
// - Selector mode 01 on: bipolar main, no trim.
// - Unassigned selector: modes 01-03 sum volt+current.
// - Unassigned selector ignores the selector mode.
// - Bipolar input acts alone or as offset.
//
// Design decisions made here: the APB interface to the registers and the address map.
module analog_input_source_selector #(
  parameter int N_OUT = 3
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               net_write,
  input  wire logic [9:0]         voltage_in,
  input  wire logic [9:0]         current_in,
  input  wire logic [10:0]        bipolar_trim_input,
  input  wire logic               analog_type_selector,
  output logic      [13:0]        freq_cmd,
  output logic                    reverse_dir,
  output logic                    trim_active,
  output logic                    reverse_avail,
  output logic                    cmd_from_analog,
  output logic      [N_OUT-1:0]   out_term
);

  typedef struct packed {
    logic                       main_src;
    logic                       trim;
    logic                       rev;
  } dummy_t;

  typedef struct packed {
    analog_sel_pkg::main_src_t  main_src;
    logic                       trim;
    logic                       rev;
  } route_t;

  typedef struct packed {
    logic                       at_meta;
    logic                       at_sync;
    logic [2:0]                 freq_src;
    logic [2:0]                 run_src;
    logic                       sel_mode;
    logic [1:0]                 aux_mode;
    logic                       sel_asg;
    logic [4:0]                 filter;
    logic [N_OUT-1:0][7:0]      out_code;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
    logic [13:0]                freq_cmd;
    logic                       reverse_dir;
    logic                       trim_active;
    logic                       reverse_avail;
    logic                       cmd_from_analog;
    analog_sel_pkg::main_src_t  main_src;
    logic [N_OUT-1:0]           out_term;
  } state_t;

  state_t             st_reg;
  state_t             st_next;
  route_t             rt;
  logic signed [13:0] v_val;
  logic signed [13:0] c_val;
  logic signed [13:0] b_val;
  logic signed [13:0] main_val;
  logic signed [13:0] total;
  logic               access;
  logic               refuse;
  logic [31:0]        rd;
  logic [N_OUT-1:0][7:0] new_code;

  filt_if fl ();

  sample_filter u_filter (
    .clk  (clk),
    .nrst (nrst),
    .f    (fl.flt)
  );

  // Decode of the selection table
  function automatic route_t route(
    input logic [1:0] aux,
    input logic       mode,
    input logic       asg,
    input logic       at
  );
    route_t r;
    r.main_src = analog_sel_pkg::SRC_VOLT;
    r.trim     = 1'b0;
    r.rev      = 1'b0;
    if (!asg) begin
      unique case (aux)
        analog_sel_pkg::AUX_BIPOLAR: begin
          r.main_src = analog_sel_pkg::SRC_BIP;
          r.rev      = 1'b1;
        end
        analog_sel_pkg::AUX_UNIPOLAR: begin
          r.main_src = analog_sel_pkg::SRC_SUM;
          r.trim     = 1'b1;
        end
        analog_sel_pkg::AUX_REVERSE: begin
          r.main_src = analog_sel_pkg::SRC_SUM;
          r.trim     = 1'b1;
          r.rev      = 1'b1;
        end
        analog_sel_pkg::AUX_NO_TRIM: begin
          r.main_src = analog_sel_pkg::SRC_SUM;
        end
      endcase
    end else if (mode && at) begin
      r.main_src = analog_sel_pkg::SRC_BIP;
      r.rev      = 1'b1;
    end else begin
      r.main_src = at ? analog_sel_pkg::SRC_CUR : analog_sel_pkg::SRC_VOLT;
      r.trim = (aux == analog_sel_pkg::AUX_UNIPOLAR) || (aux == analog_sel_pkg::AUX_REVERSE);
      r.rev  = (aux == analog_sel_pkg::AUX_REVERSE);
    end
    return r;
  endfunction

  always_comb begin
    st_next = st_reg;

    // Selector pin synchroniser
    st_next.at_meta = analog_type_selector;
    st_next.at_sync = st_reg.at_meta;

    // Samples into the filter
    fl.setting = st_reg.filter;
    fl.raw[0]  = {2'b00, voltage_in};
    fl.raw[1]  = {2'b00, current_in};
    fl.raw[2]  = {bipolar_trim_input[10], bipolar_trim_input};

    // Selection and command, every cycle
    rt    = route(st_reg.aux_mode, st_reg.sel_mode, st_reg.sel_asg, st_reg.at_sync);
    v_val = $signed({{2{fl.filt[0][11]}}, fl.filt[0]});
    c_val = $signed({{2{fl.filt[1][11]}}, fl.filt[1]});
    b_val = $signed({{2{fl.filt[2][11]}}, fl.filt[2]});
    if (!rt.rev && b_val < 14'sh0) begin
      b_val = 14'sh0;
    end
    unique case (rt.main_src)
      analog_sel_pkg::SRC_VOLT: main_val = v_val;
      analog_sel_pkg::SRC_CUR:  main_val = c_val;
      analog_sel_pkg::SRC_BIP:  main_val = b_val;
      analog_sel_pkg::SRC_SUM:  main_val = v_val + c_val;
    endcase
    total = rt.trim ? main_val + b_val : main_val;

    st_next.main_src        = rt.main_src;
    st_next.trim_active     = rt.trim;
    st_next.reverse_avail   = rt.rev;
    st_next.cmd_from_analog = (st_reg.freq_src == analog_sel_pkg::FREQ_SRC_ANALOG);
    if (st_next.cmd_from_analog) begin
      st_next.freq_cmd    = total;
      st_next.reverse_dir = total < 14'sh0;
    end else begin
      st_next.freq_cmd    = 14'h0000;
      st_next.reverse_dir = 1'b0;
    end

    // Intelligent output terminals
    for (int i = 0; i < N_OUT; i++) begin
      st_next.out_term[i] = (st_reg.out_code[i] == analog_sel_pkg::RUN_MON_CODE)
                            && (st_reg.run_src == analog_sel_pkg::RUN_SRC_KEYPAD);
    end

    // Write legality
    refuse = 1'b0;
    for (int i = 0; i < N_OUT; i++) begin
      new_code[i] = pwdata[8*i +: 8];
    end
    unique case (paddr)
      analog_sel_pkg::CFG_OFF: begin
        refuse = pwrite && (pwdata[analog_sel_pkg::FILTER_LSB +: 5] < analog_sel_pkg::FILTER_MIN
              || pwdata[analog_sel_pkg::FILTER_LSB +: 5] > analog_sel_pkg::FILTER_MAX);
      end
      analog_sel_pkg::OUT_ASSIGN_OFF: begin
        for (int i = 0; i < N_OUT; i++) begin
          if (pwrite && net_write
              && ((st_reg.out_code[i] == analog_sel_pkg::RUN_MON_CODE)
               != (new_code[i] == analog_sel_pkg::RUN_MON_CODE))) begin
            refuse = 1'b1;
          end
        end
      end
      analog_sel_pkg::STATUS_OFF,
      analog_sel_pkg::CMD_OFF: begin
        refuse = pwrite;
      end
      default: begin
        refuse = 1'b1;
      end
    endcase

    // Read data
    rd = 32'h0000_0000;
    unique case (paddr)
      analog_sel_pkg::CFG_OFF: begin
        rd[analog_sel_pkg::FREQ_SRC_LSB +: 3] = st_reg.freq_src;
        rd[analog_sel_pkg::RUN_SRC_LSB +: 3]  = st_reg.run_src;
        rd[analog_sel_pkg::SEL_MODE_BIT]      = st_reg.sel_mode;
        rd[analog_sel_pkg::AUX_MODE_LSB +: 2] = st_reg.aux_mode;
        rd[analog_sel_pkg::SEL_ASG_BIT]       = st_reg.sel_asg;
        rd[analog_sel_pkg::FILTER_LSB +: 5]   = st_reg.filter;
      end
      analog_sel_pkg::STATUS_OFF: begin
        rd[1:0] = st_reg.main_src;
        rd[2]   = st_reg.trim_active;
        rd[3]   = st_reg.reverse_avail;
        rd[4]   = st_reg.cmd_from_analog;
        rd[5]   = st_reg.at_sync;
        rd[6]   = st_reg.run_src == analog_sel_pkg::RUN_SRC_KEYPAD;
        rd[7]   = st_reg.reverse_dir;
      end
      analog_sel_pkg::OUT_ASSIGN_OFF: begin
        for (int i = 0; i < N_OUT; i++) begin
          rd[8*i +: 8] = st_reg.out_code[i];
        end
      end
      analog_sel_pkg::CMD_OFF: begin
        rd[13:0] = st_reg.freq_cmd;
      end
      default: begin
        rd = 32'h0000_0000;
      end
    endcase

    // APB slave, one wait state
    access = psel && penable;
    if (access && !st_reg.pready) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = refuse;
      st_next.prdata  = pwrite ? 32'h0000_0000 : rd;
    end else begin
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.prdata  = 32'h0000_0000;
    end
    if (access && st_reg.pready && pwrite && !st_reg.pslverr) begin
      unique case (paddr)
        analog_sel_pkg::CFG_OFF: begin
          st_next.freq_src = pwdata[analog_sel_pkg::FREQ_SRC_LSB +: 3];
          st_next.run_src  = pwdata[analog_sel_pkg::RUN_SRC_LSB +: 3];
          st_next.sel_mode = pwdata[analog_sel_pkg::SEL_MODE_BIT];
          st_next.aux_mode = pwdata[analog_sel_pkg::AUX_MODE_LSB +: 2];
          st_next.sel_asg  = pwdata[analog_sel_pkg::SEL_ASG_BIT];
          st_next.filter   = pwdata[analog_sel_pkg::FILTER_LSB +: 5];
        end
        analog_sel_pkg::OUT_ASSIGN_OFF: begin
          st_next.out_code = new_code;
        end
        default: begin
          st_next.filter = st_reg.filter;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg          <= '0;
      st_reg.freq_src <= analog_sel_pkg::FREQ_SRC_RST;
      st_reg.run_src  <= analog_sel_pkg::RUN_SRC_RST;
      st_reg.sel_mode <= analog_sel_pkg::SEL_MODE_RST;
      st_reg.aux_mode <= analog_sel_pkg::AUX_MODE_RST;
      st_reg.sel_asg  <= analog_sel_pkg::SEL_ASG_RST;
      st_reg.filter   <= analog_sel_pkg::FILTER_RST;
      st_reg.out_code <= {N_OUT{analog_sel_pkg::OUT_CODE_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata          = st_reg.prdata;
  assign pready          = st_reg.pready;
  assign pslverr         = st_reg.pslverr;
  assign freq_cmd        = st_reg.freq_cmd;
  assign reverse_dir     = st_reg.reverse_dir;
  assign trim_active     = st_reg.trim_active;
  assign reverse_avail   = st_reg.reverse_avail;
  assign cmd_from_analog = st_reg.cmd_from_analog;
  assign out_term        = st_reg.out_term;

endmodule

// ### tb/analog_sel_chk.sv
// Port checker for the analog input source selector.
// Assumes it is bound into every selector instance by the bind at the foot.
module analog_sel_chk #(
  parameter int N_OUT = 3
) (
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [13:0]      freq_cmd,
  input wire logic             reverse_dir,
  input wire logic             reverse_avail,
  input wire logic             cmd_from_analog,
  input wire logic [N_OUT-1:0] out_term
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence access_start;
    psel && $rose(penable);
  endsequence
  sequence one_wait_ready;
    !pready ##1 pready;
  endsequence
  sequence done_write2;
    $past(pready && pwrite && !pslverr, 2);
  endsequence

  ready_wait_a: assert property (access_start |-> one_wait_ready)
    else $error("access not answered after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error without ready");
  reverse_sign_a: assert property (reverse_dir |-> freq_cmd[13] && cmd_from_analog)
    else $error("reverse without negative analog command");
  reverse_allow_a: assert property (freq_cmd[13] |-> reverse_avail)
    else $error("negative command while reverse unavailable");
  term_change_a: assert property ($changed(out_term) && $past(nrst, 2) |-> done_write2)
    else $error("output terminal changed without a write");
  src_change_a: assert property ($changed(cmd_from_analog) && $past(nrst, 2) |-> done_write2)
    else $error("analog source flag changed without a write");
endmodule

bind analog_input_source_selector analog_sel_chk #(.N_OUT(N_OUT)) chk_i (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .freq_cmd(freq_cmd),
  .reverse_dir(reverse_dir), .reverse_avail(reverse_avail),
  .cmd_from_analog(cmd_from_analog), .out_term(out_term)
);

// ### tb/analog_src.sv
// Model of the external analog sources and the selector pin.
// Assumes the bench sets the bipolar level and selector state.
module analog_src (
  input  wire logic        clk,
  input  wire logic [10:0] bip_t,
  input  wire logic        sel_t,
  output logic      [9:0]  voltage_in,
  output logic      [9:0]  current_in,
  output logic      [10:0] bipolar_trim_input,
  output logic             analog_type_selector
);
  timeunit 1ns;
  timeprecision 1ps;
  // Fixed unipolar source levels
  assign voltage_in = 10'h0c8;
  assign current_in = 10'h064;
  always @(posedge clk) begin
    bipolar_trim_input   <= bip_t;
    analog_type_selector <= sel_t;
  end
endmodule

// ### tb/test_analog_input_source_selector.sv
// Self-checking bench for the analog input source selector.
// Assumes the bound checker and the analog source model.
module test_analog_input_source_selector;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, psel, penable, pwrite, net_write, sel_t;
  logic        pready, pslverr, reverse_dir, trim_active, reverse_avail, cmd_from_analog, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  voltage_in, current_in;
  logic [10:0] bip, bip_t;
  logic        at_pin;
  logic [13:0] freq_cmd;
  logic [2:0]  out_term;
  logic [3:0]  ex;
  int          n_mismatch = 0;
  int          checks = 0;
  int          k;

  analog_src analog_src_i (.clk(clk), .bip_t(bip_t), .sel_t(sel_t), .voltage_in(voltage_in),
    .current_in(current_in), .bipolar_trim_input(bip), .analog_type_selector(at_pin));
  analog_input_source_selector #(.N_OUT(3)) analog_input_source_selector_i (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .net_write(net_write), .voltage_in(voltage_in), .current_in(current_in),
    .bipolar_trim_input(bip), .analog_type_selector(at_pin), .freq_cmd(freq_cmd),
    .reverse_dir(reverse_dir), .trim_active(trim_active), .reverse_avail(reverse_avail),
    .cmd_from_analog(cmd_from_analog), .out_term(out_term));

  task stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_mismatch++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] cfgw(input logic [2:0] fs, input logic [2:0] rs,
      input logic mode, input logic [1:0] aux, input logic asg, input logic [4:0] f);
    return {11'h000, f, 3'h0, asg, aux, 1'b0, mode, 1'b0, rs, 1'b0, fs};
  endfunction

  // Expected {reverse, trim, main source}
  function automatic logic [3:0] sel_exp(input logic [1:0] aux, input logic asg,
      input logic mode, input logic at);
    logic sw;
    sw = asg && mode && at;
    return {(aux == 2'h2) || (asg ? sw : aux == 2'h0),
            (aux == 2'h1 || aux == 2'h2) && !sw,
            !asg ? (aux == 2'h0 ? 2'h2 : 2'h3) : (sw ? 2'h2 : {1'b0, at})};
  endfunction

  task wait_rev(input logic e);
    for (int i = 0; i < 300 && reverse_dir !== e; i++) @(negedge clk);
    chk(32'(reverse_dir), 32'(e));
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    {nrst, psel, penable, pwrite, net_write, sel_t} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    bip_t = 11'h000;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, analog_sel_pkg::CFG_OFF, 32'h0);
    chk(rd, 32'h0008_1011);
    chk(32'(cmd_from_analog), 32'h1);
    $display("reset test done");
    apb(1'b1, analog_sel_pkg::OUT_ASSIGN_OFF, 32'h001b_051b);
    for (k = 1; k <= 5; k++) begin
      apb(1'b1, analog_sel_pkg::CFG_OFF, cfgw(3'h1, 3'(k), 1'b0, 2'h0, 1'b1, 5'h08));
      repeat (2) @(posedge clk);
      chk(32'(out_term), k == 2 ? 32'h5 : 32'h0);
    end
    net_write <= 1'b1;
    apb(1'b1, analog_sel_pkg::OUT_ASSIGN_OFF, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, analog_sel_pkg::OUT_ASSIGN_OFF, 32'h001b_1b1b);
    chk(32'(err), 32'h1);
    apb(1'b1, analog_sel_pkg::OUT_ASSIGN_OFF, 32'h001b_061b);
    chk(32'(err), 32'h0);
    apb(1'b0, analog_sel_pkg::OUT_ASSIGN_OFF, 32'h0);
    chk(rd, 32'h001b_061b);
    net_write <= 1'b0;
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("monitor test done");
    for (k = 0; k < 4; k++) begin
      apb(1'b1, analog_sel_pkg::CFG_OFF, cfgw(3'h1, 3'h1, 1'b0, 2'h0, 1'b1, 5'(k * 10 + 1)));
      chk(32'(err), k == 3 ? 32'h1 : 32'h0);
    end
    apb(1'b1, analog_sel_pkg::CFG_OFF, cfgw(3'h1, 3'h1, 1'b0, 2'h0, 1'b1, 5'h00));
    chk(32'(err), 32'h1);
    apb(1'b0, analog_sel_pkg::CFG_OFF, 32'h0);
    chk(rd, cfgw(3'h1, 3'h1, 1'b0, 2'h0, 1'b1, 5'h15));
    $display("filter test done");
    for (k = 0; k < 32; k++) begin
      sel_t <= k[0];
      if (!k[0])
        apb(1'b1, analog_sel_pkg::CFG_OFF, cfgw(3'h1, 3'h1, k[1], k[4:3], k[2], 5'h08));
      repeat (4) @(posedge clk);
      apb(1'b0, analog_sel_pkg::STATUS_OFF, 32'h0);
      ex = sel_exp(k[4:3], k[2], k[1], k[0]);
      chk(32'(rd[6:0]), {26'h0, k[0], 1'b1, ex});
      chk(32'({trim_active, reverse_avail}), 32'({ex[2], ex[3]}));
    end
    $display("selection test done");
    sel_t <= 1'b0;
    bip_t <= 11'h738;
    apb(1'b1, analog_sel_pkg::CFG_OFF, cfgw(3'h1, 3'h1, 1'b0, 2'h0, 1'b0, 5'h01));
    wait_rev(1'b1);
    apb(1'b1, analog_sel_pkg::CFG_OFF, cfgw(3'h1, 3'h1, 1'b0, 2'h1, 1'b0, 5'h01));
    wait_rev(1'b0);
    apb(1'b0, analog_sel_pkg::CMD_OFF, 32'h0);
    chk(rd, 32'(freq_cmd));
    chk(32'(freq_cmd[13]), 32'h0);
    apb(1'b1, analog_sel_pkg::CFG_OFF, cfgw(3'h0, 3'h1, 1'b0, 2'h0, 1'b0, 5'h01));
    repeat (4) @(posedge clk);
    wait_rev(1'b0);
    chk(32'(cmd_from_analog), 32'h0);
    chk(32'(freq_cmd), 32'h0);
    $display("direction test done");
    stop_test();
  end
endmodule
